/* File: core/pwr_mode_ctrl.sv */
// power-mode controller: two control registers, mode state machine, wake wait counter, clock gating
// assumes a cpu that pulses sleep_req_i on a sleep instruction and wake_ack_i once an interrupt is accepted
//
// Behaviour
// (R1) primary register: 8 bits at FFF0, resets to 07
// (R2) standby select 0: sleep goes active to sleep, subactive to subsleep
// (R3) standby select 1: sleep goes active to standby/watch, subactive to watch
// (R4) 3-bit wait field picks wake wait length in states, reset 000
// (R5) software picks 2-state wait only with an external clock
// (R6) low-speed select picks system clock or subclock after watch ends
// (R7) primary bit 2 reads 1, ignores writes
// (R8) 2-bit divider picks oscillator/16,/32,/64,/128; reset /128
// (R9) software writes the divider only in high-speed active or subactive
// (R10) secondary register at FFF1, reset F0, top three bits read 1
// (R11) software clears noise filter bit for 2 to 16 MHz oscillator
// (R12) interrupt request alone changes no mode; needs accepted interrupt
// (R13) high-speed active: cpu and peripherals on full system clock
// (R14) medium-speed active: cpu and peripherals on divided system clock
// (R15) subactive: cpu runs on the subclock
// (R16) high-speed sleep: cpu stopped, peripherals on system clock
// (R17) medium-speed sleep: cpu stopped, peripherals on divided clock
// (R18) subsleep: cpu stopped, subclock peripherals may run
// (R19) watch: cpu stopped, timekeeping, one timer, counter, display run
// (R20) standby: cpu, peripherals and system oscillator stopped
// (R21) module standby halts chosen peripherals individually
// (R22) standby: ports keep contents, outputs go high impedance
// (R23) direct-transfer bit makes sleep switch between active modes directly
// (R24) medium-speed select picks active mode entered after a wake
// (R25) subactive clock field: /8, /4, /2; frozen in subactive
// (R26) noise filter bit 0 samples at /16, 1 at /4
// (R27) after standby/watch wake, count selected states before release; a watch wake into subactive skips the count
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "pwr_mode_defs.svh"

module pwr_mode_ctrl #(
  parameter int MOD_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sleep_req_i,
  input wire logic wake_ack_i,
  input wire logic timekeeping_select_i,
  input wire logic [MOD_W-1:0] module_stby_i,
  output pwr_mode_pkg::pwr_mode_t mode_o,
  output logic cpu_run_o,
  output logic cpu_on_sub_o,
  output logic periph_run_o,
  output logic periph_on_sub_o,
  output logic sys_osc_en_o,
  output logic port_hiz_o,
  output logic [MOD_W-1:0] module_clk_en_o,
  output logic [1:0] med_div_o,
  output logic [1:0] sub_rate_o,
  output logic noise_rate_fast_o
);
  import pwr_mode_pkg::*;

  // ==========================================================
  // registers
  logic standby_select_q;
  logic [2:0] wait_select_q;
  logic low_speed_select_q;
  logic [1:0] medium_divider_q;
  logic noise_filter_rate_q;
  logic direct_transfer_select_q;
  logic medium_speed_select_q;
  logic [1:0] sub_clock_rate_q;
  pwr_mode_t mode_q, mode_d;
  logic [14:0] wait_cnt_q;
  logic [7:0] primary_rd, secondary_rd;
  localparam logic [7:0] PRI_RST = `PMC_PRIMARY_RST;
  localparam logic [7:0] SEC_RST = `PMC_SECONDARY_RST;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      standby_select_q <= PRI_RST[`PMC_STANDBY_BIT];
      wait_select_q <= PRI_RST[`PMC_WAIT_HI:`PMC_WAIT_LO];
      low_speed_select_q <= PRI_RST[`PMC_LOW_SPEED_BIT];
      medium_divider_q <= PRI_RST[`PMC_MED_DIV_HI:`PMC_MED_DIV_LO];
    end
    else if (wr_i && addr_i == `PMC_PRIMARY_ADDR) // R1
    begin
      standby_select_q <= wdata_i[`PMC_STANDBY_BIT];
      wait_select_q <= wdata_i[`PMC_WAIT_HI:`PMC_WAIT_LO]; // R4
      low_speed_select_q <= wdata_i[`PMC_LOW_SPEED_BIT]; // R6
      medium_divider_q <= wdata_i[`PMC_MED_DIV_HI:`PMC_MED_DIV_LO]; // R8
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      noise_filter_rate_q <= SEC_RST[`PMC_NOISE_BIT];
      direct_transfer_select_q <= SEC_RST[`PMC_DIRECT_BIT];
      medium_speed_select_q <= SEC_RST[`PMC_MED_SEL_BIT];
      sub_clock_rate_q <= SEC_RST[`PMC_SUB_RATE_HI:`PMC_SUB_RATE_LO];
    end
    else if (wr_i && addr_i == `PMC_SECONDARY_ADDR) // R10
    begin
      noise_filter_rate_q <= wdata_i[`PMC_NOISE_BIT]; // R26
      direct_transfer_select_q <= wdata_i[`PMC_DIRECT_BIT]; // R23
      medium_speed_select_q <= wdata_i[`PMC_MED_SEL_BIT]; // R24
      if (mode_q != MODE_SUBACT)
      begin
        sub_clock_rate_q <= wdata_i[`PMC_SUB_RATE_HI:`PMC_SUB_RATE_LO]; // R25
      end
    end
  end

  // ==========================================================
  // read port
  always_comb
  begin
    primary_rd = {standby_select_q, wait_select_q, low_speed_select_q, 1'b0, medium_divider_q}
      | `PMC_PRIMARY_FIXED; // R7
    secondary_rd = {3'h0, noise_filter_rate_q, direct_transfer_select_q, medium_speed_select_q,
      sub_clock_rate_q} | `PMC_SECONDARY_FIXED; // R10
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_i && addr_i == `PMC_PRIMARY_ADDR)
    begin
      rdata_o <= primary_rd;
    end
    else if (rd_i && addr_i == `PMC_SECONDARY_ADDR)
    begin
      rdata_o <= secondary_rd;
    end
    else
    begin
      rdata_o <= 8'h00;
    end
  end

  // ==========================================================
  // wake wait length
  function automatic logic [14:0] wait_len(input logic [2:0] sel);
    logic [14:0] n;
    n = `PMC_WAIT_8192;
    unique case (sel)
      3'h0: n = `PMC_WAIT_8192;
      3'h1: n = `PMC_WAIT_16384;
      3'h2: n = `PMC_WAIT_1024;
      3'h3: n = `PMC_WAIT_2048;
      3'h4: n = `PMC_WAIT_4096;
      3'h5: n = `PMC_WAIT_2;
      3'h6: n = `PMC_WAIT_8;
      3'h7: n = `PMC_WAIT_16;
    endcase
    return n;
  endfunction : wait_len

  // ==========================================================
  // mode state machine
  logic act_mode;
  assign act_mode = (mode_q == MODE_ACT_HIGH) || (mode_q == MODE_ACT_MED);

  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      MODE_ACT_HIGH, MODE_ACT_MED:
      begin
        if (sleep_req_i)
        begin
          if (direct_transfer_select_q) // R23
          begin
            if (standby_select_q && timekeeping_select_i && low_speed_select_q)
              mode_d = MODE_SUBACT;
            else if (!standby_select_q && !low_speed_select_q)
              mode_d = medium_speed_select_q ? MODE_ACT_MED : MODE_ACT_HIGH;
          end
          else if (!standby_select_q) // R2
            mode_d = medium_speed_select_q ? MODE_SLP_MED : MODE_SLP_HIGH;
          else // R3
            mode_d = timekeeping_select_i ? MODE_WATCH : MODE_STANDBY;
        end
      end
      MODE_SUBACT:
      begin
        if (sleep_req_i)
        begin
          if (direct_transfer_select_q && standby_select_q && timekeeping_select_i
              && !low_speed_select_q)
            mode_d = MODE_WAKE_WAIT; // R23
          else if (!standby_select_q)
            mode_d = MODE_SUBSLP; // R2
          else
            mode_d = MODE_WATCH; // R3
        end
      end
      MODE_SLP_HIGH:
        if (wake_ack_i) mode_d = MODE_ACT_HIGH; // R12
      MODE_SLP_MED:
        if (wake_ack_i) mode_d = MODE_ACT_MED; // R12
      MODE_SUBSLP:
        if (wake_ack_i) mode_d = MODE_SUBACT; // R12
      MODE_WATCH:
        if (wake_ack_i) mode_d = low_speed_select_q ? MODE_SUBACT : MODE_WAKE_WAIT; // R6 R12
      MODE_STANDBY:
        if (wake_ack_i) mode_d = MODE_WAKE_WAIT; // R12
      MODE_WAKE_WAIT:
        if (wait_cnt_q == 15'h0001)
          mode_d = medium_speed_select_q ? MODE_ACT_MED : MODE_ACT_HIGH; // R24 R27
      default:
        mode_d = MODE_ACT_HIGH;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mode_q <= MODE_ACT_HIGH;
    else
      mode_q <= mode_d;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wait_cnt_q <= 15'h0000;
    else if (mode_q != MODE_WAKE_WAIT && mode_d == MODE_WAKE_WAIT)
      wait_cnt_q <= wait_len(wait_select_q); // R4 R27
    else if (mode_q == MODE_WAKE_WAIT && wait_cnt_q != 15'h0000)
      wait_cnt_q <= wait_cnt_q - 15'h0001; // R27
  end

  // ==========================================================
  // clock and run outputs, registered from next mode and the control registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode_o <= MODE_ACT_HIGH;
      cpu_run_o <= 1'b1;
      cpu_on_sub_o <= 1'b0;
      periph_run_o <= 1'b1;
      periph_on_sub_o <= 1'b0;
      sys_osc_en_o <= 1'b1;
      port_hiz_o <= 1'b0;
      module_clk_en_o <= '1;
      med_div_o <= PRI_RST[`PMC_MED_DIV_HI:`PMC_MED_DIV_LO];
      sub_rate_o <= SEC_RST[`PMC_SUB_RATE_HI:`PMC_SUB_RATE_LO];
      noise_rate_fast_o <= SEC_RST[`PMC_NOISE_BIT];
    end
    else
    begin
      mode_o <= mode_d;
      cpu_run_o <= mode_d inside {MODE_ACT_HIGH, MODE_ACT_MED, MODE_SUBACT}; // R13 R14 R15 R16
      cpu_on_sub_o <= mode_d == MODE_SUBACT; // R15
      periph_run_o <= mode_d inside {MODE_ACT_HIGH, MODE_ACT_MED, MODE_SLP_HIGH, MODE_SLP_MED,
        MODE_SUBACT, MODE_SUBSLP, MODE_WATCH}; // R17 R18 R19 R20
      periph_on_sub_o <= mode_d inside {MODE_SUBACT, MODE_SUBSLP, MODE_WATCH}; // R18 R19
      sys_osc_en_o <= !(mode_d inside {MODE_STANDBY, MODE_WATCH, MODE_SUBACT, MODE_SUBSLP}); // R20
      port_hiz_o <= mode_d == MODE_STANDBY; // R22
      module_clk_en_o <= (mode_d == MODE_STANDBY) ? '0 : ~module_stby_i; // R21
      med_div_o <= medium_divider_q; // R14 R17
      sub_rate_o <= sub_clock_rate_q; // R25
      noise_rate_fast_o <= noise_filter_rate_q; // R26
    end
  end

  // ==========================================================
  // checks
  chk_primary_reads_fixed: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_i && addr_i == `PMC_PRIMARY_ADDR |=> rdata_o[2]) // R7
    else $error("primary bit 2 not read as one");
  chk_secondary_top_bits: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_i && addr_i == `PMC_SECONDARY_ADDR |=> rdata_o[7:5] == 3'h7) // R10
    else $error("secondary top bits not read as one");
  chk_no_wake_without_ack: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    mode_q inside {MODE_STANDBY, MODE_WATCH, MODE_SLP_HIGH} && !wake_ack_i |=> $stable(mode_q)) // R12
    else $error("mode left without accepted interrupt");
  chk_sleep_standby_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    act_mode && sleep_req_i && !standby_select_q && !direct_transfer_select_q
    |=> mode_q inside {MODE_SLP_HIGH, MODE_SLP_MED}) // R2
    else $error("sleep did not enter sleep mode");
  chk_sleep_standby_one: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    act_mode && sleep_req_i && standby_select_q && !direct_transfer_select_q
    |=> mode_q inside {MODE_STANDBY, MODE_WATCH}) // R3
    else $error("sleep did not enter standby or watch");
  chk_wait_short: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    mode_q == MODE_STANDBY && wake_ack_i && wait_select_q == 3'h6
    |=> mode_q == MODE_WAKE_WAIT [*8] ##1 act_mode) // R27
    else $error("eight state wake wait wrong");
  chk_standby_outputs: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    mode_q == MODE_STANDBY |-> !sys_osc_en_o && !cpu_run_o && port_hiz_o) // R20 R22
    else $error("standby outputs wrong");
  chk_sub_rate_frozen: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    mode_q == MODE_SUBACT && $past(mode_q) == MODE_SUBACT |-> $stable(sub_clock_rate_q)) // R25
    else $error("subactive clock field changed");
  chk_sub_to_subsleep: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R2
    mode_q == MODE_SUBACT && sleep_req_i && !standby_select_q |=> mode_q == MODE_SUBSLP)
    else $error("subactive sleep did not enter subsleep");
  chk_wait_two: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R4 R27
    mode_q == MODE_STANDBY && wake_ack_i && wait_select_q == 3'h5 |=> mode_q == MODE_WAKE_WAIT [*2] ##1 act_mode)
    else $error("two state wake wait wrong");
  chk_direct_to_sub: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R23
    act_mode && sleep_req_i && direct_transfer_select_q && standby_select_q && timekeeping_select_i && low_speed_select_q |=> mode_q == MODE_SUBACT)
    else $error("direct transfer to subactive missing");
  chk_sub_to_active: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R23
    mode_q == MODE_SUBACT && sleep_req_i && direct_transfer_select_q && standby_select_q && timekeeping_select_i && !low_speed_select_q |=> mode_q == MODE_WAKE_WAIT)
    else $error("direct transfer from subactive missing");
  chk_hiz_only_standby: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R22
    port_hiz_o |-> mode_q == MODE_STANDBY)
    else $error("ports released outside standby");
  chk_standby_modules_off: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R20 R21
    mode_q == MODE_STANDBY |-> module_clk_en_o == '0)
    else $error("module clock running in standby");
  chk_watch_on_sub: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R19
    mode_q == MODE_WATCH |-> periph_on_sub_o && !cpu_run_o && !sys_osc_en_o)
    else $error("watch outputs wrong");
  chk_sleep_cpu_halt: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R16 R17
    mode_q inside {MODE_SLP_HIGH, MODE_SLP_MED} |-> !cpu_run_o && periph_run_o && sys_osc_en_o)
    else $error("sleep outputs wrong");
  chk_active_full_run: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R13 R14
    act_mode |-> cpu_run_o && periph_run_o && !cpu_on_sub_o)
    else $error("active outputs wrong");
  chk_sub_cpu_clock: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // R15
    mode_q == MODE_SUBACT |-> cpu_run_o && cpu_on_sub_o && !sys_osc_en_o)
    else $error("subactive outputs wrong");

  // ==========================================================
  // covers
  cov_sleep_wake: cover property (@(posedge clk_sys_i) mode_q == MODE_SLP_HIGH ##1 mode_q == MODE_ACT_HIGH);
  cov_direct_sub: cover property (@(posedge clk_sys_i) act_mode ##1 mode_q == MODE_SUBACT);
  cov_sub_direct_wake: cover property (@(posedge clk_sys_i) mode_q == MODE_SUBACT ##1 mode_q == MODE_WAKE_WAIT);
  cov_standby_wake: cover property (@(posedge clk_sys_i) mode_q == MODE_WAKE_WAIT ##1 act_mode);
  cov_subact: cover property (@(posedge clk_sys_i) mode_q == MODE_SUBACT);
endmodule : pwr_mode_ctrl

/* File: core/pwr_mode_defs.svh */
// register offsets, field positions, reset values and timing counts for the power-mode controller
// assumes inclusion by bare name from the design file
`ifndef PWR_MODE_DEFS_SVH
`define PWR_MODE_DEFS_SVH

`define PMC_PRIMARY_ADDR 16'hFFF0
`define PMC_SECONDARY_ADDR 16'hFFF1
`define PMC_PRIMARY_RST 8'h07
`define PMC_SECONDARY_RST 8'hF0
`define PMC_PRIMARY_FIXED 8'h04
`define PMC_SECONDARY_FIXED 8'hE0
`define PMC_STANDBY_BIT 7
`define PMC_WAIT_HI 6
`define PMC_WAIT_LO 4
`define PMC_LOW_SPEED_BIT 3
`define PMC_MED_DIV_HI 1
`define PMC_MED_DIV_LO 0
`define PMC_NOISE_BIT 4
`define PMC_DIRECT_BIT 3
`define PMC_MED_SEL_BIT 2
`define PMC_SUB_RATE_HI 1
`define PMC_SUB_RATE_LO 0
`define PMC_WAIT_8192 15'h2000
`define PMC_WAIT_16384 15'h4000
`define PMC_WAIT_1024 15'h0400
`define PMC_WAIT_2048 15'h0800
`define PMC_WAIT_4096 15'h1000
`define PMC_WAIT_2 15'h0002
`define PMC_WAIT_8 15'h0008
`define PMC_WAIT_16 15'h0010

`endif

/* File: core/pwr_mode_pkg.sv */
// types for the power-mode controller
// needs no constants header; only the design file includes it
package pwr_mode_pkg;
  typedef enum logic [9:0] {
    MODE_ACT_HIGH = 10'h001,
    MODE_ACT_MED = 10'h002,
    MODE_SUBACT = 10'h004,
    MODE_SLP_HIGH = 10'h008,
    MODE_SLP_MED = 10'h010,
    MODE_SUBSLP = 10'h020,
    MODE_WATCH = 10'h040,
    MODE_STANDBY = 10'h080,
    MODE_WAKE_WAIT = 10'h100,
    MODE_WAKE_SUB = 10'h200
  } pwr_mode_t;
endpackage : pwr_mode_pkg

/* File: dv/power_down_mode_control_test.sv */
// self-checking bench for the power-mode controller
// assumes pwr_mode_pkg compiled first and the constants header on the include path
`timescale 1ns/1ps
module power_down_mode_control_test;
  import pwr_mode_pkg::*;
  localparam int CYC_MAX = 6000;
  logic clk_sys_i, arst_n_i, wr_i, rd_i, sleep_req_i, wake_ack_i, timekeeping_select_i;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o, module_stby_i, module_clk_en_o, d, wp, ws;
  pwr_mode_t mode_o;
  logic cpu_run_o, cpu_on_sub_o, periph_run_o, periph_on_sub_o, sys_osc_en_o, port_hiz_o, noise_rate_fast_o;
  logic [1:0] med_div_o, sub_rate_o;
  int error_cnt, comparisons, cyc, n;
  integer seed;
  pwr_mode_ctrl pwr_mode_ctrl_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_req_i(sleep_req_i),
    .wake_ack_i(wake_ack_i), .timekeeping_select_i(timekeeping_select_i), .module_stby_i(module_stby_i),
    .mode_o(mode_o), .cpu_run_o(cpu_run_o), .cpu_on_sub_o(cpu_on_sub_o), .periph_run_o(periph_run_o),
    .periph_on_sub_o(periph_on_sub_o), .sys_osc_en_o(sys_osc_en_o), .port_hiz_o(port_hiz_o),
    .module_clk_en_o(module_clk_en_o), .med_div_o(med_div_o), .sub_rate_o(sub_rate_o),
    .noise_rate_fast_o(noise_rate_fast_o));
  // ==========================================
  // clock, timeout, checks
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == CYC_MAX)
    begin
      error_cnt++;
      test_done();
    end
  end
  function automatic int exp_wait(input logic [2:0] c);
    case (c)
      3'h0: return 8192;
      3'h1: return 16384;
      3'h2: return 1024;
      3'h3: return 2048;
      3'h4: return 4096;
      3'h5: return 2;
      3'h6: return 8;
      default: return 16;
    endcase
  endfunction : exp_wait
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_mode(input pwr_mode_t got, input pwr_mode_t exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_mode
  task automatic st(input pwr_mode_t m, input logic c);
    chk_mode(mode_o, m);
    chk_val(cpu_run_o, c);
  endtask : st
  task automatic test_done();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  // ==========================================
  // bus and control drivers
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd_reg
  task automatic pulse(input bit wake);
    @(posedge clk_sys_i);
    if (wake)
      wake_ack_i <= 1'b1;
    else
      sleep_req_i <= 1'b1;
    @(posedge clk_sys_i);
    wake_ack_i <= 1'b0;
    sleep_req_i <= 1'b0;
    #1;
  endtask : pulse
  // wait states counted while the wake wait mode shows
  task automatic wake_wait(input bit wake, input logic [2:0] c);
    pulse(wake);
    chk_mode(mode_o, MODE_WAKE_WAIT);
    n = 0;
    while (mode_o === MODE_WAKE_WAIT && n < 20000)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk_val(16'(n), 16'(exp_wait(c)));
  endtask : wake_wait
  // ==========================================
  // main sequence
  initial
  begin
    seed = 32'h1e45;
    {arst_n_i, wr_i, rd_i, sleep_req_i, wake_ack_i, timekeeping_select_i} = '0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    module_stby_i = 8'h00;
    repeat (10) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd_reg(16'hFFF0, d);
    chk_val(d, 8'h07);
    rd_reg(16'hFFF1, d);
    chk_val(d, 8'hF0);
    rd_reg(16'h1234, d);
    chk_val(d, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wp = 8'($random(seed));
      ws = 8'($random(seed));
      wr_reg(16'hFFF0, wp);
      module_stby_i <= 8'($random(seed));
      wr_reg(16'hFFF1, ws);
      rd_reg(16'hFFF0, d);
      chk_val(d, wp | 8'h04);
      rd_reg(16'hFFF1, d);
      chk_val(d, ws | 8'hE0);
      chk_val(med_div_o, wp[1:0]);
      chk_val(sub_rate_o, ws[1:0]);
      chk_val(noise_rate_fast_o, ws[4]);
      chk_val(module_clk_en_o, 8'(~module_stby_i));
    end
    $display("test registers done");
    // divider set once while high-speed active
    wr_reg(16'hFFF0, 8'h60);
    for (int m = 1; m >= 0; m--)
    begin
      wr_reg(16'hFFF1, 8'h10 | 8'(m << 2));
      pulse(1'b0);
      st(m ? MODE_SLP_MED : MODE_SLP_HIGH, 1'b0);
      chk_val(periph_run_o, 1'b1);
      chk_val(med_div_o, 2'h0);
      pulse(1'b0);
      chk_mode(mode_o, m ? MODE_SLP_MED : MODE_SLP_HIGH);
      pulse(1'b1);
      st(m ? MODE_ACT_MED : MODE_ACT_HIGH, 1'b1);
    end
    $display("test sleep done");
    wr_reg(16'hFFF1, 8'h10);
    // code 5 used as if an external clock drove the oscillator
    for (int c = 5; c <= 7; c++)
    begin
      wr_reg(16'hFFF0, 8'h80 | 8'(c << 4));
      pulse(1'b0);
      st(MODE_STANDBY, 1'b0);
      chk_val({periph_run_o, sys_osc_en_o, module_clk_en_o}, 10'h000);
      chk_val(port_hiz_o, 1'b1);
      pulse(1'b0);
      chk_mode(mode_o, MODE_STANDBY);
      wake_wait(1'b1, 3'(c));
      st(MODE_ACT_HIGH, 1'b1);
      chk_val({sys_osc_en_o, port_hiz_o}, 2'h2);
    end
    $display("test standby done");
    @(posedge clk_sys_i);
    timekeeping_select_i <= 1'b1;
    wr_reg(16'hFFF0, 8'hF8);
    pulse(1'b0);
    st(MODE_WATCH, 1'b0);
    chk_val(periph_on_sub_o, 1'b1);
    pulse(1'b1);
    st(MODE_SUBACT, 1'b1);
    chk_val(cpu_on_sub_o, 1'b1);
    wr_reg(16'hFFF1, 8'h13);
    @(posedge clk_sys_i);
    #1;
    chk_val(sub_rate_o, 2'h0);
    wr_reg(16'hFFF0, 8'h78);
    pulse(1'b0);
    st(MODE_SUBSLP, 1'b0);
    chk_val(periph_on_sub_o, 1'b1);
    pulse(1'b1);
    st(MODE_SUBACT, 1'b1);
    wr_reg(16'hFFF0, 8'hF0);
    pulse(1'b0);
    st(MODE_WATCH, 1'b0);
    wake_wait(1'b1, 3'h7);
    st(MODE_ACT_HIGH, 1'b1);
    chk_val(periph_on_sub_o, 1'b0);
    $display("test watch done");
    wr_reg(16'hFFF1, 8'h1C);
    wr_reg(16'hFFF0, 8'h70);
    pulse(1'b0);
    st(MODE_ACT_MED, 1'b1);
    chk_val(periph_run_o, 1'b1);
    wr_reg(16'hFFF1, 8'h18);
    pulse(1'b0);
    st(MODE_ACT_HIGH, 1'b1);
    pulse(1'b1);
    st(MODE_ACT_HIGH, 1'b1);
    wr_reg(16'hFFF0, 8'hF8);
    pulse(1'b0);
    st(MODE_SUBACT, 1'b1);
    wr_reg(16'hFFF0, 8'hF0);
    wake_wait(1'b0, 3'h7);
    st(MODE_ACT_HIGH, 1'b1);
    $display("test direct done");
    test_done();
  end
endmodule : power_down_mode_control_test
